// ---- verilog/xrc_pkg.sv ----
// package: constants and types of the reference and receive clock control
package xrc_pkg;
    // ---------------------------------------------------------------
    // bus map
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_PERIOD = 4'h8;
    localparam int CTRL_PRIM_OFF = 0;
    localparam int CTRL_AUX_OFF = 1;
    localparam int CTRL_SOFT_RST = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int STAT_LOCKED = 0;
    localparam int STAT_DATA = 1;
    localparam int STAT_IN_RST = 2;
    localparam int STAT_STATE = 3;
    localparam int STAT_REFSRC = 6;
    // ---------------------------------------------------------------
    // widths, ratios and timing
    // ---------------------------------------------------------------
    localparam int RX_WORD_W = 16;
    localparam int CNT_W = 16;
    localparam logic [5:0] RATIO_W16 = 6'h10;
    localparam logic [5:0] RATIO_W4 = 6'h04;
    localparam logic [5:0] RATIO_REF16 = 6'h10;
    localparam logic [5:0] RATIO_REF32 = 6'h20;
    localparam logic [4:0] WIN_REFS = 5'h10;
    localparam logic [CNT_W-1:0] LOCK_TOL = 16'h0008;
    localparam logic [7:0] DATA_TIMEOUT_CYC = 8'h40;
    localparam int CLK_MHZ = 250;
    localparam int RESET_MIN_NS = 1000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    // ---------------------------------------------------------------
    // receive loop modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ACQ = 3'b001,
        ST_TRACK = 3'b010,
        ST_REFLOCK = 3'b100
    } xrc_state_t;
endpackage

// ---- verilog/xrc_gate_if.sv ----
// interface: raw clock, enable and gated clock between top and gate
`timescale 1ns/100ps
`default_nettype none
interface xrc_gate_if;
    logic raw;
    logic en;
    logic gated;
    modport ctl (output raw, output en, input gated);
    modport gate (input raw, input en, output gated);
endinterface // xrc_gate_if
`default_nettype wire

// ---- verilog/xrc_clk_gate.sv ----
// module: glitch-free gate for one receive clock output
`timescale 1ns/100ps
`default_nettype none
module xrc_clk_gate (
    input wire logic clk_sys,
    input wire logic rstn,
    xrc_gate_if.gate g
);
    import xrc_pkg::*;
    logic en_r;
    logic gated_r;
    // enable changes only while the raw clock is low
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_r <= 1'b0;
        end else if (!g.raw) begin
            en_r <= g.en;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gated_r <= 1'b0;
        end else begin
            gated_r <= g.raw & en_r;
        end
    end
    assign g.gated = gated_r;
    a_gate_static: assert property (@(posedge clk_sys) disable iff (!rstn)
        !g.en && !g.raw |=> ##1 !gated_r)
        else $error("disabled clock still toggles");
    a_gate_no_runt: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(gated_r) |-> $past(g.raw) && !$past(g.raw, 2))
        else $error("gated clock rose mid phase");
endmodule // xrc_clk_gate
`default_nettype wire

// ---- verilog/xrc_rst_filter.sv ----
// module: minimum-width filter for the active-low device reset pin
`timescale 1ns/100ps
`default_nettype none
module xrc_rst_filter #(
    parameter int MIN_CYC = xrc_pkg::RESET_MIN_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin_n,
    output logic dev_rst
);
    import xrc_pkg::*;
    localparam logic [9:0] MIN_C = 10'(MIN_CYC);
    logic [9:0] low_cnt_r;
    logic dev_rst_r;
    // count low cycles, saturating at the minimum width
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            low_cnt_r <= 10'h000;
        end else if (pin_n) begin
            low_cnt_r <= 10'h000;
        end else if (low_cnt_r != MIN_C) begin
            low_cnt_r <= low_cnt_r + 10'h001;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dev_rst_r <= 1'b0;
        end else begin
            dev_rst_r <= !pin_n && (low_cnt_r >= MIN_C - 10'h001);
        end
    end
    assign dev_rst = dev_rst_r;
    a_rst_min_width: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(dev_rst_r) |-> low_cnt_r == MIN_C)
        else $error("device reset taken from a short pulse");
    a_rst_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        pin_n |=> !dev_rst_r)
        else $error("device reset held with pin high");
endmodule // xrc_rst_filter
`default_nettype wire

// ---- verilog/xrc_top.sv ----
// module: reference select, receive clock derivation and reset control
//
// Operation
// - select 0 takes the parallel transmit input clock as reference, select 1 the dedicated input.
// - the chosen reference paces the transmit multiplier that makes the serial transmit clock.
// - the receive loop centers on the chosen reference while acquiring and judges lock against it.
// - the reset pin held low for at least 1 us resets the device, and high means normal running.
// - the primary receive clock is the recovered clock divided to the parallel word rate.
// - with no line data and lock-to-reference low, the primary receive clock stays stable.
// - the auxiliary clock equals the word rate when its select is high, and a quarter of it when low.
// - a low primary disable input turns the primary receive clock off.
// - a low auxiliary disable input turns the auxiliary receive clock off.
// - both receive clocks and the 16-bit receive word come from the recovered serial signal.
// - lock-to-reference low locks the loop to the reference, high lets it track the line.
// - width select high gives 16-bit words and low 4-bit words, setting the word rate.
// - the dedicated reference counts as 1/16th of the line rate with rate select high, 1/32nd low.
`timescale 1ns/100ps
`default_nettype none
module xrc_top (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ref_source_select,
    input wire logic parallel_tx_input_clock,
    input wire logic dedicated_reference_input,
    input wire logic ref_rate_select,
    input wire logic word_width_select,
    input wire logic lock_to_reference_n,
    input wire logic serial_line_input,
    input wire logic line_bit_tick,
    input wire logic aux_clock_divide_select,
    input wire logic primary_clock_off_n,
    input wire logic aux_clock_off_n,
    input wire logic device_reset_n,
    output logic serial_tx_output_clock,
    output logic primary_rx_clock_out,
    output logic auxiliary_rx_clock_out,
    output logic [xrc_pkg::RX_WORD_W-1:0] parallel_rx_word_bus
);
    import xrc_pkg::*;
    // ---------------------------------------------------------------
    // pin capture
    // ---------------------------------------------------------------
    logic ref_source_select_r, rate_r, width_r, ltr_n_r, auxdiv_r, prim_on_r, aux_on_r, rst_pin_r;
    logic txin_r, dref_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ref_source_select_r <= 1'b1;
            rate_r <= 1'b1;
            width_r <= 1'b1;
            ltr_n_r <= 1'b1;
            auxdiv_r <= 1'b1;
            prim_on_r <= 1'b1;
            aux_on_r <= 1'b1;
            rst_pin_r <= 1'b1;
        end else begin
            ref_source_select_r <= ref_source_select;
            rate_r <= ref_rate_select;
            width_r <= word_width_select;
            ltr_n_r <= lock_to_reference_n;
            auxdiv_r <= aux_clock_divide_select;
            prim_on_r <= primary_clock_off_n;
            aux_on_r <= aux_clock_off_n;
            rst_pin_r <= device_reset_n;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txin_r <= 1'b0;
            dref_r <= 1'b0;
        end else begin
            txin_r <= parallel_tx_input_clock;
            dref_r <= dedicated_reference_input;
        end
    end
    // ---------------------------------------------------------------
    // device reset
    // ---------------------------------------------------------------
    logic pin_rst;
    logic [2:0] ctrl_r;
    logic srst;
    xrc_rst_filter #(.MIN_CYC(RESET_MIN_CYC)) u_rst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_n(rst_pin_r),
        .dev_rst(pin_rst)
    );
    assign srst = pin_rst | ctrl_r[CTRL_SOFT_RST];
    // ---------------------------------------------------------------
    // reference selection and ratio
    // ---------------------------------------------------------------
    logic ref_lvl, ref_lvl_d_r, ref_edge;
    logic [5:0] ratio;
    logic [4:0] width;
    assign width = width_r ? 5'h10 : 5'h04;
    assign ref_lvl = ref_source_select_r ? dref_r : txin_r;
    always_comb begin
        if (!ref_source_select_r) begin
            ratio = width_r ? RATIO_W16 : RATIO_W4;
        end else begin
            ratio = rate_r ? RATIO_REF16 : RATIO_REF32;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ref_lvl_d_r <= 1'b0;
        end else begin
            ref_lvl_d_r <= ref_lvl;
        end
    end
    assign ref_edge = ref_lvl & ~ref_lvl_d_r;
    // ---------------------------------------------------------------
    // transmit multiplier: period measure and bit-rate accumulator
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] per_cnt_r, period_r;
    logic [CNT_W:0] acc_r, acc_sum;
    logic ref_tick;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            per_cnt_r <= '0;
            period_r <= '0;
        end else if (srst) begin
            per_cnt_r <= '0;
            period_r <= '0;
        end else if (ref_edge) begin
            per_cnt_r <= 16'h0001;
            period_r <= per_cnt_r;
        end else if (per_cnt_r != 16'hFFFF) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
        end
    end
    // ratio ticks per reference period
    assign acc_sum = acc_r + {11'h000, ratio};
    assign ref_tick = (period_r != '0) && (acc_sum >= {1'b0, period_r});
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc_r <= '0;
        end else if (srst || period_r == '0) begin
            acc_r <= '0;
        end else if (ref_tick) begin
            acc_r <= acc_sum - {1'b0, period_r};
        end else begin
            acc_r <= acc_sum;
        end
    end
    logic tx_clk_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_clk_r <= 1'b0;
        end else if (srst) begin
            tx_clk_r <= 1'b0;
        end else if (ref_tick) begin
            tx_clk_r <= ~tx_clk_r;
        end
    end
    assign serial_tx_output_clock = tx_clk_r;
    // ---------------------------------------------------------------
    // lock judgement and data detect
    // ---------------------------------------------------------------
    logic [4:0] win_r;
    logic [CNT_W-1:0] bits_r, expect_v, diff;
    logic locked_r, data_r;
    logic [7:0] idle_r;
    assign expect_v = {6'h00, ratio, 4'h0};
    assign diff = (bits_r > expect_v) ? bits_r - expect_v : expect_v - bits_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            win_r <= 5'h00;
            bits_r <= '0;
            locked_r <= 1'b0;
        end else if (srst) begin
            win_r <= 5'h00;
            bits_r <= '0;
            locked_r <= 1'b0;
        end else if (ref_edge && win_r == WIN_REFS - 5'h01) begin
            win_r <= 5'h00;
            bits_r <= '0;
            locked_r <= diff <= LOCK_TOL;
        end else begin
            if (ref_edge) begin
                win_r <= win_r + 5'h01;
            end
            if (line_bit_tick && bits_r != 16'hFFFF) begin
                bits_r <= bits_r + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idle_r <= 8'h00;
            data_r <= 1'b0;
        end else if (line_bit_tick) begin
            idle_r <= 8'h00;
            data_r <= 1'b1;
        end else if (idle_r == DATA_TIMEOUT_CYC) begin
            data_r <= 1'b0;
        end else begin
            idle_r <= idle_r + 8'h01;
        end
    end
    // ---------------------------------------------------------------
    // receive loop mode
    // ---------------------------------------------------------------
    xrc_state_t state_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_ACQ;
        end else if (srst) begin
            state_r <= ST_ACQ;
        end else if (!ltr_n_r) begin
            state_r <= ST_REFLOCK;
        end else begin
            unique case (state_r)
                ST_ACQ: begin
                    if (locked_r && data_r) begin
                        state_r <= ST_TRACK;
                    end
                end
                ST_TRACK, ST_REFLOCK: begin
                    if (!locked_r || !data_r) begin
                        state_r <= ST_ACQ;
                    end else begin
                        state_r <= ST_TRACK;
                    end
                end
            endcase
        end
    end
    logic rec_tick;
    // line ticks only while tracking, reference ticks otherwise
    assign rec_tick = (state_r == ST_TRACK) ? line_bit_tick : ref_tick;
    // ---------------------------------------------------------------
    // word divider and deserializer
    // ---------------------------------------------------------------
    logic [4:0] bit_cnt_r;
    logic word_tick;
    logic [RX_WORD_W-1:0] shift_r, word_r;
    assign word_tick = rec_tick && (bit_cnt_r >= width - 5'h01);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_r <= 5'h00;
        end else if (srst) begin
            bit_cnt_r <= 5'h00;
        end else if (word_tick) begin
            bit_cnt_r <= 5'h00;
        end else if (rec_tick) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shift_r <= '0;
            word_r <= '0;
        end else if (srst) begin
            shift_r <= '0;
            word_r <= '0;
        end else if (rec_tick) begin
            shift_r <= {shift_r[RX_WORD_W-2:0], serial_line_input};
            if (word_tick) begin
                word_r <= width_r ? {shift_r[RX_WORD_W-2:0], serial_line_input}
                                  : {12'h000, shift_r[2:0], serial_line_input};
            end
        end
    end
    assign parallel_rx_word_bus = word_r;
    // ---------------------------------------------------------------
    // raw receive clocks
    // ---------------------------------------------------------------
    logic prim_raw_r, aux_raw_r;
    logic [1:0] quarter_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            quarter_r <= 2'h0;
        end else if (srst) begin
            quarter_r <= 2'h0;
        end else if (word_tick) begin
            quarter_r <= quarter_r + 2'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prim_raw_r <= 1'b0;
            aux_raw_r <= 1'b0;
        end else if (srst) begin
            prim_raw_r <= 1'b0;
            aux_raw_r <= 1'b0;
        end else begin
            prim_raw_r <= bit_cnt_r < {1'b0, width[4:1]};
            aux_raw_r <= auxdiv_r ? (bit_cnt_r < {1'b0, width[4:1]}) : !quarter_r[1];
        end
    end
    // ---------------------------------------------------------------
    // output gates
    // ---------------------------------------------------------------
    xrc_gate_if prim_if ();
    xrc_gate_if aux_if ();
    assign prim_if.raw = prim_raw_r;
    assign prim_if.en = prim_on_r & ~ctrl_r[CTRL_PRIM_OFF];
    assign aux_if.raw = aux_raw_r;
    assign aux_if.en = aux_on_r & ~ctrl_r[CTRL_AUX_OFF];
    xrc_clk_gate u_prim_gate (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .g(prim_if.gate)
    );
    xrc_clk_gate u_aux_gate (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .g(aux_if.gate)
    );
    assign primary_rx_clock_out = prim_if.gated;
    assign auxiliary_rx_clock_out = aux_if.gated;
    // ---------------------------------------------------------------
    // avalon slave
    // ---------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdata_r, status_v;
    logic req;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign status_v = {25'h0000000, ref_source_select_r, state_r, pin_rst, data_r, locked_r};
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RESET;
        end else if (avs_write && ack_r && avs_address == OFS_CTRL && avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[2:0];
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            unique case (avs_address)
                OFS_CTRL: rdata_r <= {29'h00000000, ctrl_r};
                OFS_STATUS: rdata_r <= status_v;
                OFS_PERIOD: rdata_r <= {16'h0000, period_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end
    assign avs_readdata = rdata_r;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_ref_pick;
        !ref_source_select_r ##0 (ratio == (width_r ? RATIO_W16 : RATIO_W4));
    endsequence
    a_ref_select: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ref_source_select_r |-> s_ref_pick)
        else $error("wrong ratio for transmit input reference");
    a_ref_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
        ref_source_select_r |-> ratio == (rate_r ? 6'h10 : 6'h20))
        else $error("wrong ratio for dedicated reference");
    a_reflock_mode: assert property (@(posedge clk_sys) disable iff (!rstn || srst)
        !ltr_n_r |=> state_r == ST_REFLOCK)
        else $error("loop not locked to reference");
    a_track_source: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_r != ST_TRACK && ref_tick |-> rec_tick)
        else $error("reference ticks not used off track");
    sequence s_word_done;
        word_tick ##1 bit_cnt_r == 5'h00;
    endsequence
    a_word_width: assert property (@(posedge clk_sys) disable iff (!rstn || srst)
        word_tick |-> ($past(bit_cnt_r) + 5'h01 == bit_cnt_r || bit_cnt_r >= width - 5'h01) ##0 s_word_done)
        else $error("word boundary wrong");
    a_narrow_word: assert property (@(posedge clk_sys) disable iff (!rstn || srst)
        word_tick && !width_r |=> word_r[15:4] == 12'h000)
        else $error("upper word bits set in narrow mode");
    a_aux_quarter: assert property (@(posedge clk_sys) disable iff (!rstn || srst)
        !auxdiv_r && !$past(srst) |=> aux_raw_r == !$past(quarter_r[1]))
        else $error("aux clock not a quarter of word rate");
    a_bus_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
        req && !ack_r |=> !avs_waitrequest)
        else $error("bus answer missing");
    a_tx_pace: assert property (@(posedge clk_sys) disable iff (!rstn || srst)
        period_r == '0 |=> $stable(tx_clk_r))
        else $error("transmit clock runs without reference");
endmodule // xrc_top
`default_nettype wire

// ---- test/xrc_far_end.sv ----
// model of the board reference sources and the recovered line stream
`timescale 1ns/100ps
`default_nettype none
module xrc_far_end (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic line_on,
    output logic ref_par,
    output logic ref_ded,
    output logic line_tick,
    output logic line_bit
);
    logic [6:0] cnt_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 7'h01;
        end
    end
    // parallel reference every 64 cycles, dedicated every 128
    assign ref_par = cnt_r[5];
    assign ref_ded = cnt_r[6];
    // one line bit each 4 cycles while data is present; data keeps changing
    assign line_tick = line_on & (cnt_r[1:0] == 2'h3);
    assign line_bit = cnt_r[2] ^ cnt_r[5];
endmodule // xrc_far_end
`default_nettype wire

// ---- test/xcvr_dedicated_reference_input_and_rx_clock_ctrl_tb_top.sv ----
// testbench: bus, reference, receive clock and reset checks
`timescale 1ns/100ps
`default_nettype none
module xcvr_dedicated_reference_input_and_rx_clock_ctrl_tb_top;
    import xrc_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, rd_s = 1'b0, wr_s = 1'b0, wait_s, line_on = 1'b0;
    logic rsel = 1'b0, rate = 1'b0, wsel = 1'b1, ltr_n = 1'b0, adiv = 1'b1, poff_n = 1'b1, aoff_n = 1'b1;
    logic drst_n = 1'b1, tx, prim, aux, rp, rdd, tick, lbit;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [15:0] word;
    logic [2:0] prv = 3'h0, now_w;
    logic [2:0] cfg [5] = '{3'h1, 3'h0, 3'h7, 3'h5, 3'h4};
    int num_errors = 0, n_tests = 0, ticks, words;
    int cnt [3];
    xrc_far_end far (.clk_sys(clk_sys), .rstn(rstn), .line_on(line_on), .ref_par(rp), .ref_ded(rdd),
        .line_tick(tick), .line_bit(lbit));
    xrc_top dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wait_s),
        .ref_source_select(rsel), .parallel_tx_input_clock(rp), .dedicated_reference_input(rdd),
        .ref_rate_select(rate), .word_width_select(wsel), .lock_to_reference_n(ltr_n),
        .serial_line_input(lbit), .line_bit_tick(tick), .aux_clock_divide_select(adiv),
        .primary_clock_off_n(poff_n), .aux_clock_off_n(aoff_n), .device_reset_n(drst_n),
        .serial_tx_output_clock(tx), .primary_rx_clock_out(prim), .auxiliary_rx_clock_out(aux),
        .parallel_rx_word_bus(word));
    assign now_w = {tx, aux, prim};
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // edges counted off the sampling edge
    always @(negedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] += int'(now_w[i] & ~prv[i]);
        end
        prv <= now_w;
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdat <= d;
        wr_s <= wr;
        rd_s <= ~wr;
        do @(posedge clk_sys); while (wait_s !== 1'b0);
        rd = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge clk_sys);
    endtask
    // window of 1024 cycles holds whole periods of every clock seen
    task automatic measure(input int pw, input int pa, input int pt);
        cnt = '{0, 0, 0};
        repeat (1024) @(posedge clk_sys);
        check("primary edges", cnt[0], pw);
        check("aux edges", cnt[1], pa);
        check("tx edges", cnt[2], pt);
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        for (int k = 0; k < 5; k++) begin
            {rsel, rate, wsel} <= cfg[k];
            repeat (600) @(posedge clk_sys);
            ticks = (cfg[k][2] ? 8 : 16) * (cfg[k][2] ? (cfg[k][1] ? 16 : 32) : (cfg[k][0] ? 16 : 4));
            words = ticks / (cfg[k][0] ? 16 : 4);
            measure(words, words, ticks / 2);
            bus(1'b0, OFS_STATUS, 32'h0);
            check("ref source", 32'(rd[STAT_REFSRC]), 32'(cfg[k][2]));
            check("reflock state", 32'(rd[5:3]), 32'h4);
            bus(1'b0, OFS_PERIOD, 32'h0);
            check("ref period", rd, cfg[k][2] ? 32'h80 : 32'h40);
            check("narrow word top", 32'(word[15:4] & {12{~cfg[k][0]}}), 32'h0);
        end
        adiv <= 1'b0;
        repeat (600) @(posedge clk_sys);
        measure(64, 16, 128);
        {poff_n, aoff_n} <= 2'b00;
        repeat (40) @(posedge clk_sys);
        measure(0, 0, 128);
        bus(1'b1, OFS_CTRL, 32'h1);
        {poff_n, aoff_n, adiv} <= 3'b111;
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl readback", 32'(rd[2:0]), 32'h1);
        repeat (40) @(posedge clk_sys);
        measure(0, 64, 128);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        check("unmapped read", rd, 32'h0);
        {rsel, rate, wsel, ltr_n, line_on} <= 5'b00111;
        repeat (3000) @(posedge clk_sys);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("track status", 32'(rd[5:0]), 32'h13);
        measure(16, 16, 128);
        line_on <= 1'b0;
        repeat (600) @(posedge clk_sys);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("loss status", 32'(rd[5:1]), 32'h4);
        drst_n <= 1'b0;
        repeat (200) @(posedge clk_sys);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("short reset", 32'(rd[STAT_IN_RST]), 32'h0);
        repeat (60) @(posedge clk_sys);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("long reset", 32'(rd[STAT_IN_RST]), 32'h1);
        check("word cleared", 32'(word), 32'h0);
        drst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("reset released", 32'(rd[STAT_IN_RST]), 32'h0);
        stop_test();
    end
endmodule // xcvr_dedicated_reference_input_and_rx_clock_ctrl_tb_top
`default_nettype wire
